//--- hw/sdc_pkg.sv
// Shared constants of the synthesizer configuration bank and its controller
package sdc_pkg;
   // Serial word layout
   localparam int WORD_W = 32;
   localparam int SEL_LSB = 0;
   localparam int SEL_W = 3;
   localparam logic [2:0] SEL_INT_FRAC = 3'h0;
   localparam logic [2:0] SEL_PHASE_MOD = 3'h1;
   localparam logic [2:0] SEL_REF_PIN = 3'h2;
   // Integer and fraction divider word
   localparam int INT_LSB = 15;
   localparam int INT_W = 16;
   localparam int FRAC_LSB = 3;
   localparam int FRAC_W = 12;
   localparam logic [15:0] INT_RST = 16'h0064;
   localparam logic [11:0] FRAC_RST = 12'h000;
   // Phase, modulus and band-hold word
   localparam int HOLD_POS = 28;
   localparam int PHASE_LSB = 15;
   localparam int PHASE_W = 12;
   localparam int MOD_LSB = 3;
   localparam int MOD_W = 12;
   localparam logic HOLD_RST = 1'b0;
   localparam logic [11:0] PHASE_RST = 12'h001;
   localparam logic [11:0] MOD_RST = 12'h002;
   localparam logic [11:0] MOD_MIN = 12'h002;
   // Reference, test pin and noise word
   localparam int NOISE_LSB = 29;
   localparam int PIN_LSB = 26;
   localparam int DOUB_POS = 25;
   localparam int HALF_POS = 24;
   localparam int RDIV_LSB = 14;
   localparam int RDIV_W = 10;
   localparam int STAGED_POS = 13;
   localparam logic [1:0] NOISE_RST = 2'h0;
   localparam logic [1:0] NOISE_LOW_SPUR = 2'h3;
   localparam logic [2:0] PIN_RST = 3'h0;
   localparam logic [9:0] RDIV_RST = 10'h001;
   // Test pin source codes
   localparam logic [2:0] PIN_HIZ = 3'h0;
   localparam logic [2:0] PIN_SUPPLY = 3'h1;
   localparam logic [2:0] PIN_GROUND_LEVEL = 3'h2;
   localparam logic [2:0] PIN_REF_CNT = 3'h3;
   localparam logic [2:0] PIN_FB_CNT = 3'h4;
   localparam logic [2:0] PIN_LOCK = 3'h6;
   localparam logic [2:0] PIN_READBACK = 3'h7;
   // Timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int SCLK_HALF_NS = 25;
   localparam int CS_SETUP_NS = 10;
   localparam int CS_GAP_NS = 20;
   localparam int SCLK_HALF_CYC =
      (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CS_SETUP_CYC =
      (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CS_GAP_CYC = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Controller register map
   localparam logic [3:0] HOST_DATA = 4'h0;
   localparam logic [3:0] HOST_CTRL = 4'h4;
   localparam logic [3:0] HOST_STATUS = 4'h8;
   localparam int CTRL_GO = 0;
   localparam int CTRL_CLEAR = 1;
   localparam int ST_BUSY = 0;
   localparam int ST_REFUSED = 1;
   localparam int ST_SENT = 2;
   localparam int ST_PIN = 3;
endpackage : sdc_pkg

//--- hw/sdc_link_if.sv
// Serial link and test pin between controller and configuration bank
`timescale 1ns/100ps
interface sdc_link_if;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic pin_out;
   logic pin_oe;
   modport device (input sclk, input cs_n, input sdi,
      output pin_out, output pin_oe);
   modport host (output sclk, output cs_n, output sdi,
      input pin_out, input pin_oe);
endinterface : sdc_link_if

//--- hw/sdc_pin_sync.sv
// Three-stage pin synchroniser; a level counts once stages two and three agree
`timescale 1ns/100ps
module sdc_pin_sync
   import sdc_pkg::*;
#(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
)(
   // Clock and control
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   // Pin side
   input wire logic [W-1:0] d,
   // Filtered level
   output logic [W-1:0] q
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   wire [W-1:0] next_q = (s2 & s3) | (q & (s2 ^ s3));

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         s1 <= RST;
         s2 <= RST;
         s3 <= RST;
         q <= RST;
      end
      else if (ce)
      begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         q <= next_q;
      end
   end
endmodule : sdc_pin_sync

//--- hw/sdc_device.sv
// Configuration register bank of the synthesizer, loaded over the serial link
// How it works
// - Select 000 loads integer and fraction divider
// - Select 001 loads hold, phase, modulus
// - Hold clear: band selection after divider write
// - Hold set: no band selection, keep band
// - Phase at D26:D15, modulus at D14:D3
// - Width select low: plain 12-bit values
// - Controller never writes modulus below two
// - Noise field: 00 low noise, 11 dither
// - Pin: 000 open, 001 high, 010 low
// - Pin: counters, lock detect, readback; 101 reserved
// - D25 enables reference doubler
// - D24 enables reference halver
// - Reference divider 1..1023, default one, never zero
// - Noise D30:D29, pin D28:D26, divider D23:D14
// - Select 010 loads reference and pin word
// - D13 enables staged output divider update
// - Whole 32-bit word, MSB first, select held
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module sdc_device
   import sdc_pkg::*;
(
   // Clock and control
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   // Serial link and test pin
   sdc_link_if.device link,
   // Sources for the test pin
   input wire logic ref_count_in,
   input wire logic fb_count_in,
   input wire logic lock_detect_in,
   input wire logic readback_in,
   // Fraction width select from the extended register
   input wire logic fraction_width_select,
   // Divider settings
   output logic [INT_W-1:0] int_value,
   output logic [FRAC_W-1:0] frac_value,
   output logic band_hold,
   output logic band_select_start,
   output logic [15:0] phase_value,
   output logic [MOD_W-1:0] mod_value,
   // Reference and noise settings
   output logic [1:0] noise_shaping_select,
   output logic dither_enable,
   output logic [2:0] test_pin_source,
   output logic reference_doubler_enable,
   output logic reference_halver_enable,
   output logic [RDIV_W-1:0] ref_divider,
   output logic staged_update_enable
);
   logic sclk_q;
   logic cs_n_q;
   logic sdi_q;
   logic sclk_prev;
   logic cs_n_prev;
   logic [WORD_W-1:0] shift;
   logic [5:0] bit_count;
   logic [PHASE_W-1:0] phase_code;
   logic pin_out;
   logic pin_oe;

   sdc_pin_sync #(.W(3), .RST(3'h2)) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .d({link.sclk, link.cs_n, link.sdi}),
      .q({sclk_q, cs_n_q, sdi_q})
   );

   // Shift on sclk rise while selected; act only on a whole word
   wire sclk_rise = sclk_q && !sclk_prev;
   wire cs_rise = cs_n_q && !cs_n_prev;
   wire shift_en = sclk_rise && !cs_n_q;
   // A short or long frame leaves every field as it was
   wire word_done = cs_rise && (bit_count == 6'd32);
   wire [2:0] sel = shift[SEL_LSB +: SEL_W];
   wire load_int = word_done && (sel == SEL_INT_FRAC);
   wire load_phase = word_done && (sel == SEL_PHASE_MOD);
   wire load_ref = word_done && (sel == SEL_REF_PIN);
   wire [5:0] next_bit_count = cs_n_q ? 6'd0 :
      (shift_en && bit_count != 6'd33) ? bit_count + 6'd1 : bit_count;

   // Test pin source selection
   logic next_pin_out;
   logic next_pin_oe;
   always_comb
   begin
      next_pin_out = 1'b0;
      next_pin_oe = 1'b1;
      unique case (test_pin_source)
         PIN_HIZ: next_pin_oe = 1'b0;
         PIN_SUPPLY: next_pin_out = 1'b1;
         PIN_GROUND_LEVEL: next_pin_out = 1'b0;
         PIN_REF_CNT: next_pin_out = ref_count_in;
         PIN_FB_CNT: next_pin_out = fb_count_in;
         PIN_LOCK: next_pin_out = lock_detect_in;
         PIN_READBACK: next_pin_out = readback_in;
         default: next_pin_oe = 1'b0;
      endcase
   end

   // Scaling acts on the output only; the stored code stays 12 bits
   wire [15:0] next_phase_value = fraction_width_select ?
      {phase_code, 4'h0} :
      {4'h0, phase_code};

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         sclk_prev <= 1'b0;
         cs_n_prev <= 1'b1;
         shift <= '0;
         bit_count <= 6'd0;
      end
      else if (ce)
      begin
         sclk_prev <= sclk_q;
         cs_n_prev <= cs_n_q;
         bit_count <= next_bit_count;
         if (shift_en)
            shift <= {shift[WORD_W-2:0], sdi_q};
      end
   end

   // Integer and fraction divider word
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         int_value <= INT_RST;
         frac_value <= FRAC_RST;
         band_select_start <= 1'b0;
      end
      else if (ce)
      begin
         band_select_start <= load_int && !band_hold;
         if (load_int)
         begin
            int_value <= shift[INT_LSB +: INT_W];
            frac_value <= shift[FRAC_LSB +: FRAC_W];
         end
      end
   end

   // Phase, modulus and band-hold word; reserved bits are dropped
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         band_hold <= HOLD_RST;
         phase_code <= PHASE_RST;
         mod_value <= MOD_RST;
         phase_value <= {4'h0, PHASE_RST};
      end
      else if (ce)
      begin
         phase_value <= next_phase_value;
         if (load_phase)
         begin
            band_hold <= shift[HOLD_POS];
            phase_code <= shift[PHASE_LSB +: PHASE_W];
            mod_value <= shift[MOD_LSB +: MOD_W];
         end
      end
   end

   // Reference, test pin and noise word
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         noise_shaping_select <= NOISE_RST;
         dither_enable <= 1'b0;
         test_pin_source <= PIN_RST;
         reference_doubler_enable <= 1'b0;
         reference_halver_enable <= 1'b0;
         ref_divider <= RDIV_RST;
         staged_update_enable <= 1'b0;
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end
      else if (ce)
      begin
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
         // Reserved noise codes are kept as written; only 11 dithers
         dither_enable <= noise_shaping_select == NOISE_LOW_SPUR;
         if (load_ref)
         begin
            noise_shaping_select <= shift[NOISE_LSB +: 2];
            test_pin_source <= shift[PIN_LSB +: 3];
            reference_doubler_enable <= shift[DOUB_POS];
            reference_halver_enable <= shift[HALF_POS];
            ref_divider <= shift[RDIV_LSB +: RDIV_W];
            staged_update_enable <= shift[STAGED_POS];
         end
      end
   end

   assign link.pin_out = pin_out;
   assign link.pin_oe = pin_oe;
endmodule : sdc_device

//--- hw/sdc_host.sv
// Serial controller that programs the configuration bank from a register port
`timescale 1ns/100ps
module sdc_host
   import sdc_pkg::*;
#(
   parameter int HALF_CYC = SCLK_HALF_CYC
)(
   // Clock and control
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   // Register port
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Serial link
   sdc_link_if.host link
);
   // Below two half cycles the bank's pin filter misses clock phases
   if (HALF_CYC < 2 || HALF_CYC > 15)
   begin : g_half_check
      $error("HALF_CYC out of range");
   end

   typedef enum logic [2:0] {S_IDLE, S_LOW, S_HIGH, S_TAIL, S_GAP} sdc_state_t;
   sdc_state_t state;
   logic [31:0] data;
   logic [31:0] shift;
   logic [4:0] bit_idx;
   logic [3:0] wait_cnt;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic refused;
   logic sent;
   logic pin_q;

   function automatic logic word_ok(input logic [31:0] w);
      logic ok;
      ok = 1'b1;
      if (w[SEL_LSB +: SEL_W] == SEL_PHASE_MOD)
         ok = w[MOD_LSB +: MOD_W] >= MOD_MIN;
      else if (w[SEL_LSB +: SEL_W] == SEL_REF_PIN)
         ok = w[RDIV_LSB +: RDIV_W] != 10'h000;
      return ok;
   endfunction : word_ok

   sdc_pin_sync #(.W(1), .RST(1'b0)) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .d(link.pin_oe & link.pin_out),
      .q(pin_q)
   );

   wire wr_data = wr && addr == HOST_DATA;
   wire wr_ctrl = wr && addr == HOST_CTRL;
   wire go = wr_ctrl && wdata[CTRL_GO] && state == S_IDLE;
   wire start = go && word_ok(data);
   wire refuse = go && !word_ok(data);
   wire waited = wait_cnt == 4'd0;
   wire finish = state == S_GAP && waited;
   wire clear = wr_ctrl && wdata[CTRL_CLEAR];
   wire [31:0] status = {28'h0000000, pin_q, sent, refused, state != S_IDLE};
   wire [31:0] next_rdata = !rd ? 32'h00000000 :
      addr == HOST_DATA ? data :
      addr == HOST_STATUS ? status : 32'h00000000;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         data <= 32'h00000000;
         rdata <= 32'h00000000;
         refused <= 1'b0;
         sent <= 1'b0;
      end
      else if (ce)
      begin
         rdata <= next_rdata;
         if (wr_data)
            data <= wdata;
         refused <= refuse || (refused && !clear);
         sent <= finish || (sent && !clear);
      end
   end

   // Whole word, MSB first, select held low throughout
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         state <= S_IDLE;
         shift <= 32'h00000000;
         bit_idx <= 5'd0;
         wait_cnt <= 4'd0;
         sclk <= 1'b0;
         cs_n <= 1'b1;
         sdi <= 1'b0;
      end
      else if (ce)
      begin
         if (!waited)
            wait_cnt <= wait_cnt - 4'd1;
         unique case (state)
            S_IDLE:
               if (start)
               begin
                  cs_n <= 1'b0;
                  sdi <= data[31];
                  shift <= {data[30:0], 1'b0};
                  bit_idx <= 5'd0;
                  wait_cnt <= 4'(HALF_CYC - 1);
                  state <= S_LOW;
               end
            S_LOW:
               if (waited)
               begin
                  sclk <= 1'b1;
                  wait_cnt <= 4'(HALF_CYC - 1);
                  state <= S_HIGH;
               end
            S_HIGH:
               if (waited)
               begin
                  sclk <= 1'b0;
                  if (bit_idx == 5'd31)
                  begin
                     wait_cnt <= 4'(HALF_CYC - 1);
                     state <= S_TAIL;
                  end
                  else
                  begin
                     sdi <= shift[31];
                     shift <= {shift[30:0], 1'b0};
                     bit_idx <= bit_idx + 5'd1;
                     wait_cnt <= 4'(HALF_CYC - 1);
                     state <= S_LOW;
                  end
               end
            S_TAIL:
               if (waited)
               begin
                  cs_n <= 1'b1;
                  wait_cnt <= 4'(HALF_CYC + CS_GAP_CYC - 1);
                  state <= S_GAP;
               end
            S_GAP:
               if (waited)
                  state <= S_IDLE;
         endcase
      end
   end

   assign link.sclk = sclk;
   assign link.cs_n = cs_n;
   assign link.sdi = sdi;
endmodule : sdc_host

//--- verif/sdc_link_monitor.sv
// Protocol checker for the serial link between controller and bank
`timescale 1ns/100ps
module sdc_link_monitor (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Link signals
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic pin_out,
   input wire logic pin_oe
);
   logic sclk_q;
   logic [5:0] rise_cnt;
   wire logic sclk_rise = sclk && !sclk_q;
   // Counts serial clock rises within one select frame
   always_ff @(posedge clk_sys)
   begin
      sclk_q <= rst_n ? sclk : 1'b0;
      if (!rst_n || cs_n)
         rise_cnt <= 6'h00;
      else if (sclk_rise)
         rise_cnt <= rise_cnt + 6'h01;
   end
   default clocking dcb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   a_idle_sclk_low: assert property (cs_n |-> !sclk)
      else $error("serial clock high while deselected");
   a_sclk_high_len: assert property ($rose(sclk) |-> sclk[*2] ##1 !sclk)
      else $error("serial clock high phase length wrong");
   a_sclk_low_len: assert property ($fell(sclk) |-> !sclk[*2])
      else $error("serial clock low phase too short");
   a_sdi_hold_high: assert property (sclk |-> $stable(sdi))
      else $error("data changed while serial clock high");
   a_cs_setup: assert property ($fell(cs_n) |-> !sclk[*2] ##1 sclk)
      else $error("first serial clock rise misplaced");
   a_word_len: assert property ($rose(cs_n) |-> rise_cnt == 6'h20)
      else $error("frame closed without exactly 32 rises");
   a_rise_bound: assert property (!cs_n |-> rise_cnt <= 6'h20)
      else $error("more than 32 rises in one frame");
   a_cs_after_last: assert property ($rose(cs_n) |->
      !$past(sclk, 1) && !$past(sclk, 2))
      else $error("select released too soon after last fall");
   a_cs_gap: assert property ($rose(cs_n) |-> cs_n[*2])
      else $error("select gap between words too short");
   a_oe_between: assert property ($changed(pin_oe) |->
      cs_n && $past(cs_n, 3))
      else $error("test pin enable changed inside a frame");
endmodule : sdc_link_monitor

//--- verif/synth_divider_config_regs_test.sv
// Self-checking bench: controller and bank joined over the serial link
`timescale 1ns/100ps
module synth_divider_config_regs_test;
   import sdc_pkg::*;
   logic clk_sys, rst_n, ce, wr, rd, fws, rb;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, st;
   logic [2:0] p;
   logic [15:0] int_value, phase_value;
   logic [11:0] frac_value, mod_value;
   logic [1:0] noise_shaping_select;
   logic [2:0] test_pin_source;
   logic [9:0] ref_divider;
   logic band_hold, band_select_start, dither_enable;
   logic reference_doubler_enable, reference_halver_enable;
   logic staged_update_enable;
   logic [7:0] oe_tab = 8'hDE;
   logic [7:0] out_tab = 8'h4A;
   int err_total = 0;
   int cmp_count = 0;
   int pulses = 0;
   int p0;
   sdc_link_if link ();
   sdc_host sdc_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .link(link));
   sdc_device sdc_device_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
      .link(link), .ref_count_in(1'b1), .fb_count_in(1'b0),
      .lock_detect_in(1'b1), .readback_in(rb),
      .fraction_width_select(fws), .int_value(int_value),
      .frac_value(frac_value), .band_hold(band_hold),
      .band_select_start(band_select_start), .phase_value(phase_value),
      .mod_value(mod_value), .noise_shaping_select(noise_shaping_select),
      .dither_enable(dither_enable), .test_pin_source(test_pin_source),
      .reference_doubler_enable(reference_doubler_enable),
      .reference_halver_enable(reference_halver_enable),
      .ref_divider(ref_divider),
      .staged_update_enable(staged_update_enable));
   sdc_link_monitor sdc_link_monitor_inst (.clk_sys(clk_sys),
      .rst_n(rst_n), .sclk(link.sclk), .cs_n(link.cs_n), .sdi(link.sdi),
      .pin_out(link.pin_out), .pin_oe(link.pin_oe));

   task summarize;
      if (err_total == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize

   task check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask : check

   task wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask : wr_reg

   task rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   // Clears flags, sends one word, waits for idle, checks the outcome flags
   task send(input logic [31:0] w, input logic bad);
      int i;
      wr_reg(HOST_CTRL, 32'h00000002);
      wr_reg(HOST_DATA, w);
      wr_reg(HOST_CTRL, 32'h00000001);
      i = 0;
      st = 32'h00000001;
      while (st[ST_BUSY] !== 1'b0 && i < 500)
      begin
         rd_reg(HOST_STATUS, st);
         i++;
      end
      repeat (10) @(posedge clk_sys);
      rd_reg(HOST_STATUS, st);
      check(st[ST_SENT:ST_REFUSED], {!bad, bad});
   endtask : send

   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
      if (band_select_start === 1'b1)
         pulses++;

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      summarize();
   end

   initial
   begin
      rst_n = 1'b0; ce = 1'b1; wr = 1'b0; rd = 1'b0; fws = 1'b0; rb = 1'b0;
      addr = 4'h0; wdata = 32'h0;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      #1;
      check({int_value, frac_value}, {INT_RST, FRAC_RST});
      check({band_hold, phase_value, mod_value},
         {HOLD_RST, 16'h0001, MOD_RST});
      check({noise_shaping_select, test_pin_source, reference_doubler_enable,
         reference_halver_enable, ref_divider, staged_update_enable},
         {NOISE_RST, PIN_RST, 2'h0, RDIV_RST, 1'b0});
      rd_reg(4'hC, st);
      check(st, 32'h0);
      // Full reference word with reserved and foreign bits set
      send({1'b1, 2'h3, 3'h3, 2'h3, 10'h3FF, 1'b1, 10'h3FF, SEL_REF_PIN},
         1'b0);
      check({noise_shaping_select, dither_enable, test_pin_source,
         reference_doubler_enable, reference_halver_enable, ref_divider,
         staged_update_enable}, {3'h7, 3'h3, 2'h3, 10'h3FF, 1'b1});
      check({int_value, mod_value}, {INT_RST, MOD_RST});
      for (int c = 0; c < 8; c++)
      begin
         p = c[2:0];
         send({1'b0, p[1:0], p, 2'h0, 10'h001, 1'b0, 10'h0, SEL_REF_PIN},
            1'b0);
         check({noise_shaping_select, dither_enable, test_pin_source},
            {p[1:0], p[1:0] == 2'h3, p});
         check(link.pin_oe, oe_tab[p]);
         if (oe_tab[p])
            check(link.pin_out, out_tab[p]);
      end
      @(posedge clk_sys);
      rb <= 1'b1;
      repeat (5) @(posedge clk_sys);
      check(link.pin_out, 1'b1);
      rd_reg(HOST_STATUS, st);
      check(st[ST_PIN], 1'b1);
      send({3'h0, 2'h0, 12'hABC, 12'hFFF, SEL_PHASE_MOD}, 1'b0);
      check({band_hold, phase_value, mod_value}, {1'b0, 16'h0ABC,
         12'hFFF});
      @(posedge clk_sys);
      fws <= 1'b1;
      repeat (3) @(posedge clk_sys);
      check(phase_value, 16'hABC0);
      fws <= 1'b0;
      p0 = pulses;
      send({1'b1, 16'h1234, 12'h567, SEL_INT_FRAC}, 1'b0);
      check({int_value, frac_value}, {16'h1234, 12'h567});
      check(pulses, p0 + 1);
      send({3'h7, 2'h2, 12'h000, 12'h002, SEL_PHASE_MOD}, 1'b0);
      check({band_hold, phase_value, mod_value},
         {1'b1, 16'h0, 12'h002});
      send({1'b0, 16'hFFFF, 12'hFFF, SEL_INT_FRAC}, 1'b0);
      check(int_value, 16'hFFFF);
      check(pulses, p0 + 1);
      send({3'h0, 2'h0, 12'h000, 12'h001, SEL_PHASE_MOD}, 1'b1);
      check(mod_value, 12'h002);
      send({6'h0, 2'h0, 10'h000, 1'b0, 10'h0, SEL_REF_PIN}, 1'b1);
      check({test_pin_source, ref_divider}, {3'h7, 10'h001});
      send(32'hFFFFFFFB, 1'b0);
      check({int_value, mod_value, ref_divider},
         {16'hFFFF, 12'h002, 10'h001});
      rd_reg(HOST_DATA, st);
      check(st, 32'hFFFFFFFB);
      // Writes are ignored while the clock enable is low
      @(posedge clk_sys);
      ce <= 1'b0;
      wr_reg(HOST_DATA, 32'h00000000);
      ce <= 1'b1;
      rd_reg(HOST_DATA, st);
      check(st, 32'hFFFFFFFB);
      summarize();
   end
endmodule : synth_divider_config_regs_test
